// ### common/ss_pkg.sv
// Notes on behaviour
// - correct level steps where neighbouring tap regions meet in the output image.
// - tap count is four, six or eight; tap select covers zero to count minus one.
// - gain enable off bypasses gain; on applies the per-tap corner gains.
// - offset enable, independent of gain; off bypasses, on adds per-tap corner offsets.
// - corner select picks which corner of the selected tap is written or read.
// - gain value of one half to just under one and a half (0x080 to 0x17F) is stored per tap and corner.
// - offset value is 8-bit two's complement, minus 128 to plus 127.
// - store command saves all gain and offset values; recall command restores them.
package ss_pkg;

  // variant tap count, one of 4, 6 or 8
  localparam int SS_TAPS    = 8;
  localparam int SS_CORNERS = 4;
  localparam int SS_ENTRIES = 32;
  localparam int SS_PIX_W   = 12;
  localparam int SS_COPY_CYCLES = 32;

  // register indices on the plain register port
  localparam logic [3:0] SS_ADDR_CTRL   = 4'h0;
  localparam logic [3:0] SS_ADDR_SELECT = 4'h1;
  localparam logic [3:0] SS_ADDR_GAIN   = 4'h2;
  localparam logic [3:0] SS_ADDR_OFFSET = 4'h3;
  localparam logic [3:0] SS_ADDR_CMD    = 4'h4;
  localparam logic [3:0] SS_ADDR_STATUS = 4'h5;

  // field positions
  localparam int SS_CTRL_GAIN_EN_BIT = 0;
  localparam int SS_CTRL_OFF_EN_BIT  = 1;
  localparam int SS_SEL_CORNER_LSB   = 0;
  localparam int SS_SEL_TAP_LSB      = 4;
  localparam int SS_CMD_STORE_BIT    = 0;
  localparam int SS_CMD_RECALL_BIT   = 1;
  localparam int SS_STAT_BUSY_BIT    = 0;
  localparam int SS_STAT_RECALL_BIT  = 1;

  // corner codes
  localparam logic [1:0] SS_CORNER_UPPER_LEFT  = 2'h0;
  localparam logic [1:0] SS_CORNER_UPPER_RIGHT = 2'h1;
  localparam logic [1:0] SS_CORNER_LOWER_LEFT  = 2'h2;
  localparam logic [1:0] SS_CORNER_LOWER_RIGHT = 2'h3;

  // gain is unsigned with 8 fraction bits; stored as signed delta from unity
  localparam logic [9:0]  SS_GAIN_UNITY = 10'h100;
  localparam logic [9:0]  SS_GAIN_MIN   = 10'h080;
  localparam logic [9:0]  SS_GAIN_MAX   = 10'h17F;
  localparam int          SS_FRAC_SHIFT = 8;
  localparam logic [11:0] SS_PIX_MAX    = 12'hFFF;

  typedef enum logic {SS_COPY_STORE, SS_COPY_RECALL} ss_copy_t;

  typedef struct packed {
    logic                valid;
    logic [2:0]          tap;
    logic [7:0]          xfrac;
    logic [7:0]          yfrac;
    logic [SS_PIX_W-1:0] data;
  } ss_pix_in_t;

  typedef struct packed {
    logic                valid;
    logic [SS_PIX_W-1:0] data;
  } ss_pix_out_t;

  typedef struct packed {
    logic                            gain_en;
    logic                            off_en;
    logic [2:0]                      tap;
    logic [1:0]                      corner;
    logic [SS_ENTRIES-1:0][7:0]      gain;
    logic [SS_ENTRIES-1:0][7:0]      off;
    logic [SS_ENTRIES-1:0][7:0]      nv_gain;
    logic [SS_ENTRIES-1:0][7:0]      nv_off;
    logic                            busy;
    ss_copy_t                        dir;
    logic [4:0]                      idx;
    logic [15:0]                     rdata;
    logic                            s1_v;
    logic [SS_PIX_W-1:0]             s1_pix;
    logic [7:0]                      s1_g;
    logic [7:0]                      s1_o;
    logic                            out_v;
    logic [SS_PIX_W-1:0]             out_pix;
  } ss_state_t;

endpackage

// ### logic/ss_seam_corr.sv
`timescale 1ns/100ps
`default_nettype none
module ss_seam_corr (
  input  wire logic                 mclk,
  input  wire logic                 resetn,
  input  wire logic [3:0]           reg_addr,
  input  wire logic [15:0]          reg_wdata,
  input  wire logic                 reg_wr,
  input  wire logic                 reg_rd,
  output logic [15:0]               reg_rdata,
  input  wire ss_pkg::ss_pix_in_t   pix_in,
  output ss_pkg::ss_pix_out_t       pix_out
);
  import ss_pkg::*;

  ss_state_t st_reg;
  ss_state_t st_next;

  ////////////////////////////////////////////////////////////////////////////
  // helpers

  // linear blend of two signed corner values, f counts 1/256 steps toward b
  function automatic logic [7:0] ss_lerp(input logic [7:0] a, input logic [7:0] b, input logic [7:0] f);
    logic signed [8:0]  diff;
    logic signed [17:0] prod;
    logic signed [9:0]  sum;
    diff = $signed({b[7], b}) - $signed({a[7], a});
    prod = diff * $signed({1'b0, f});
    sum  = $signed({{2{a[7]}}, a}) + 10'(prod >>> SS_FRAC_SHIFT);
    return sum[7:0];
  endfunction

  // clamp a written gain to the legal window and turn it into a delta
  function automatic logic [7:0] ss_gain_code(input logic [15:0] w);
    logic [9:0] g;
    g = (w > 16'(SS_GAIN_MAX)) ? SS_GAIN_MAX : w[9:0];
    if (g < SS_GAIN_MIN) begin
      g = SS_GAIN_MIN;
    end
    return 8'(g - SS_GAIN_UNITY);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // combinational next state

  logic [4:0]  sel_entry;
  logic [4:0]  base;
  logic [7:0]  g_top, g_bot, o_top, o_bot;
  logic [9:0]  gain_full;
  logic [21:0] prod;
  logic signed [15:0] sum;

  assign sel_entry = {st_reg.tap, st_reg.corner};
  assign base      = {pix_in.tap, 2'b00};

  always_comb begin
    st_next       = st_reg;
    st_next.rdata = 16'h0000;
    g_top = ss_lerp(st_reg.gain[base + 5'(SS_CORNER_UPPER_LEFT)],
                    st_reg.gain[base + 5'(SS_CORNER_UPPER_RIGHT)], pix_in.xfrac);
    g_bot = ss_lerp(st_reg.gain[base + 5'(SS_CORNER_LOWER_LEFT)],
                    st_reg.gain[base + 5'(SS_CORNER_LOWER_RIGHT)], pix_in.xfrac);
    o_top = ss_lerp(st_reg.off[base + 5'(SS_CORNER_UPPER_LEFT)],
                    st_reg.off[base + 5'(SS_CORNER_UPPER_RIGHT)], pix_in.xfrac);
    o_bot = ss_lerp(st_reg.off[base + 5'(SS_CORNER_LOWER_LEFT)],
                    st_reg.off[base + 5'(SS_CORNER_LOWER_RIGHT)], pix_in.xfrac);
    gain_full = SS_GAIN_UNITY + {{2{st_reg.s1_g[7]}}, st_reg.s1_g};
    prod = st_reg.s1_pix * gain_full;
    sum  = $signed(16'(prod >> SS_FRAC_SHIFT)) + $signed({{8{st_reg.s1_o[7]}}, st_reg.s1_o});

    // register writes; gain, offset and command writes are ignored while a store or recall runs
    if (reg_wr) begin
      if (reg_addr == SS_ADDR_CTRL) begin
        st_next.gain_en = reg_wdata[SS_CTRL_GAIN_EN_BIT];
        st_next.off_en  = reg_wdata[SS_CTRL_OFF_EN_BIT];
      end else if (reg_addr == SS_ADDR_SELECT) begin
        st_next.corner = reg_wdata[SS_SEL_CORNER_LSB +: 2];
        // out-of-range tap index leaves the tap selection unchanged
        if (32'(reg_wdata[SS_SEL_TAP_LSB +: 3]) < SS_TAPS) begin
          st_next.tap = reg_wdata[SS_SEL_TAP_LSB +: 3];
        end
      end else if (reg_addr == SS_ADDR_GAIN && !st_reg.busy) begin
        st_next.gain[sel_entry] = ss_gain_code(reg_wdata);
      end else if (reg_addr == SS_ADDR_OFFSET && !st_reg.busy) begin
        st_next.off[sel_entry] = reg_wdata[7:0];
      end else if (reg_addr == SS_ADDR_CMD && !st_reg.busy) begin
        // store wins when both bits are set
        if (reg_wdata[SS_CMD_STORE_BIT]) begin
          st_next.busy = 1'b1;
          st_next.dir  = SS_COPY_STORE;
          st_next.idx  = 5'h00;
        end else if (reg_wdata[SS_CMD_RECALL_BIT]) begin
          st_next.busy = 1'b1;
          st_next.dir  = SS_COPY_RECALL;
          st_next.idx  = 5'h00;
        end
      end
    end

    // register reads, data valid only in the following cycle
    if (reg_rd) begin
      if (reg_addr == SS_ADDR_CTRL) begin
        st_next.rdata[SS_CTRL_GAIN_EN_BIT] = st_reg.gain_en;
        st_next.rdata[SS_CTRL_OFF_EN_BIT]  = st_reg.off_en;
      end else if (reg_addr == SS_ADDR_SELECT) begin
        st_next.rdata[SS_SEL_CORNER_LSB +: 2] = st_reg.corner;
        st_next.rdata[SS_SEL_TAP_LSB +: 3]    = st_reg.tap;
      end else if (reg_addr == SS_ADDR_GAIN) begin
        st_next.rdata[9:0] = SS_GAIN_UNITY + {{2{st_reg.gain[sel_entry][7]}}, st_reg.gain[sel_entry]};
      end else if (reg_addr == SS_ADDR_OFFSET) begin
        st_next.rdata[7:0] = st_reg.off[sel_entry];
      end else if (reg_addr == SS_ADDR_STATUS) begin
        st_next.rdata[SS_STAT_BUSY_BIT]   = st_reg.busy;
        st_next.rdata[SS_STAT_RECALL_BIT] = (st_reg.dir == SS_COPY_RECALL);
      end
    end

    // one entry per cycle between active and saved sets
    if (st_reg.busy) begin
      case (st_reg.dir)
        SS_COPY_STORE: begin
          st_next.nv_gain[st_reg.idx] = st_reg.gain[st_reg.idx];
          st_next.nv_off[st_reg.idx]  = st_reg.off[st_reg.idx];
        end
        SS_COPY_RECALL: begin
          st_next.gain[st_reg.idx] = st_reg.nv_gain[st_reg.idx];
          st_next.off[st_reg.idx]  = st_reg.nv_off[st_reg.idx];
        end
        default: begin
          st_next.busy = 1'b0;
        end
      endcase
      st_next.idx = st_reg.idx + 5'h01;
      if (st_reg.idx == 5'(SS_COPY_CYCLES - 1)) begin
        st_next.busy = 1'b0;
      end
    end

    // stage 1: blend corner values over the tap region, bypass when disabled
    st_next.s1_v   = pix_in.valid;
    st_next.s1_pix = pix_in.data;
    st_next.s1_g   = st_reg.gain_en ? ss_lerp(g_top, g_bot, pix_in.yfrac) : 8'h00;
    st_next.s1_o   = st_reg.off_en ? ss_lerp(o_top, o_bot, pix_in.yfrac) : 8'h00;

    // stage 2: multiply, add, saturate to the pixel range
    st_next.out_v = st_reg.s1_v;
    if (sum < 16'sh0000) begin
      st_next.out_pix = 12'h000;
    end else if (sum > $signed({4'h0, SS_PIX_MAX})) begin
      st_next.out_pix = SS_PIX_MAX;
    end else begin
      st_next.out_pix = sum[11:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // state register; zero deltas mean unity gain and no offset

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  // outputs straight from flops
  assign reg_rdata     = st_reg.rdata;
  assign pix_out.valid = st_reg.out_v;
  assign pix_out.data  = st_reg.out_pix;

  ////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking ss_cb @(posedge mclk);
  endclocking
  default disable iff (!resetn);

  sequence store_accepted_s;
    reg_wr && reg_addr == SS_ADDR_CMD && reg_wdata[SS_CMD_STORE_BIT] && !st_reg.busy;
  endsequence

  sequence copy_runs_s;
    st_reg.busy ##32 !st_reg.busy;
  endsequence

  pixel_latency_a: assert property (pix_in.valid |-> ##2 pix_out.valid)
    else $error("pixel did not leave two cycles after entry");

  tap_range_a: assert property (32'(st_reg.tap) < SS_TAPS)
    else $error("tap selection outside variant range");

  gain_bypass_a: assert property (!st_reg.gain_en && !st_reg.off_en && st_reg.s1_v
    |=> pix_out.data == $past(st_reg.s1_pix))
    else $error("disabled correction altered the pixel");

  offset_bypass_a: assert property (pix_in.valid && !st_reg.off_en |=> st_reg.s1_o == 8'h00)
    else $error("disabled offset still applied");

  gain_clamp_a: assert property (reg_wr && reg_addr == SS_ADDR_GAIN && !st_reg.busy
    && reg_wdata < 16'(SS_GAIN_MIN) |=> st_reg.gain[$past(sel_entry)] == 8'h80)
    else $error("low gain not clamped to one half");

  gain_readback_a: assert property (reg_wr && reg_addr == SS_ADDR_GAIN && !st_reg.busy
    && reg_wdata == 16'h0140 ##2 reg_rd && reg_addr == SS_ADDR_GAIN
    |=> reg_rdata == 16'h0140)
    else $error("gain read back differs from write");

  offset_store_a: assert property (reg_wr && reg_addr == SS_ADDR_OFFSET && !st_reg.busy
    |=> st_reg.off[$past(sel_entry)] == $past(reg_wdata[7:0]))
    else $error("offset not stored as written");

  store_length_a: assert property (store_accepted_s |=> copy_runs_s)
    else $error("store did not take thirty-two cycles");

  store_match_a: assert property ($fell(st_reg.busy) && st_reg.dir == SS_COPY_STORE
    |-> st_reg.nv_gain == st_reg.gain && st_reg.nv_off == st_reg.off)
    else $error("saved set differs from active set");

  saturate_a: assert property (st_reg.s1_v && st_reg.s1_pix == SS_PIX_MAX && st_reg.s1_g == 8'h00
    && !st_reg.s1_o[7] |=> pix_out.data == SS_PIX_MAX)
    else $error("bright pixel did not saturate");

endmodule
`default_nettype wire

// ### verification/ss_tap_src.sv
`timescale 1ns/100ps
`default_nettype none
module ss_tap_src (
  input  wire logic                mclk,
  input  wire logic                resetn,
  input  wire logic                send,
  input  wire logic [2:0]          tap,
  input  wire logic [7:0]          xf,
  input  wire logic [7:0]          yf,
  input  wire logic [11:0]         data,
  output ss_pkg::ss_pix_in_t       pix
);
  import ss_pkg::*;
  ////////////////////////////////////////////////////////////////////////////////
  // sensor tap readout, one pixel per cycle while send is high
  // idle cycles clear valid and invert every other field so a stale pixel never looks reusable
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      pix <= '0;
    end else if (send) begin
      pix <= {1'b1, tap, xf, yf, data};
    end else begin
      pix <= {1'b0, ~pix[30:0]};
    end
  end
endmodule
`default_nettype wire

// ### verification/tb.sv
`timescale 1ns/100ps
`default_nettype none
module tb;
  import ss_pkg::*;
  logic mclk = 0, resetn = 0, reg_wr = 0, reg_rd = 0, src_send = 0, rd_seen = 0;
  logic [3:0]  reg_addr = 0;
  logic [15:0] reg_wdata = 0, reg_rdata, q_g, q_o;
  logic [2:0]  src_tap = 0;
  logic [7:0]  src_xf = 0, src_yf = 0;
  logic [11:0] src_data = 0;
  ss_pix_in_t  pix_in;
  ss_pix_out_t pix_out;
  int failures = 0, samples_checked = 0, seed = 38;
  logic [15:0] rd_q[$];
  logic [11:0] pix_q[$];

  always #20 mclk = ~mclk;
  ss_seam_corr ss_seam_corr_inst (.mclk(mclk), .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .pix_in(pix_in), .pix_out(pix_out));
  ss_tap_src ss_tap_src_inst (.mclk(mclk), .resetn(resetn), .send(src_send), .tap(src_tap), .xf(src_xf),
    .yf(src_yf), .data(src_data), .pix(pix_in));

  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      failures++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic tally_and_finish();
    $display("checked %0d failures %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // one-cycle strobes; a spare edge after each keeps strobe updates apart
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge mclk);
    reg_addr <= a; reg_wdata <= d; reg_wr <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [15:0] exp);
    rd_q.push_back(exp);
    @(posedge mclk);
    reg_addr <= a; reg_rd <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
  endtask
  // pixel times gain, plus signed offset, clipped to the pixel range
  function automatic logic [11:0] corr(input int p, input int g, input int o);
    int r;
    r = ((p * g) >>> 8) + o;
    return (r < 0) ? 12'h000 : (r > 4095) ? 12'hFFF : r[11:0];
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // read data stand only in the cycle after the strobe; pixels pop in order
  always @(posedge mclk) rd_seen <= reg_rd;
  always @(negedge mclk) begin
    if (rd_seen) chk("reg_rdata", reg_rdata, rd_q.pop_front());
    if (pix_out.valid === 1'b1) chk("pix_out", {4'h0, pix_out.data}, {4'h0, pix_q.pop_front()});
  end
  initial begin
    repeat (20000) @(posedge mclk);
    failures++;
    tally_and_finish();
  end

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (5) @(posedge mclk);
    resetn <= 1'b1;
    // reset values, then an unmapped index
    rd(SS_ADDR_CTRL, 16'h0000); rd(SS_ADDR_SELECT, 16'h0000); rd(SS_ADDR_GAIN, 16'h0100);
    rd(SS_ADDR_OFFSET, 16'h0000); rd(SS_ADDR_STATUS, 16'h0000); rd(4'hF, 16'h0000);
    // last tap and corner, gain clamped at both ends, most negative offset
    wr(SS_ADDR_SELECT, 16'h0073); wr(SS_ADDR_GAIN, 16'h0010); rd(SS_ADDR_GAIN, 16'h0080);
    wr(SS_ADDR_GAIN, 16'h0200); rd(SS_ADDR_GAIN, 16'h017F);
    wr(SS_ADDR_OFFSET, 16'h0080); rd(SS_ADDR_OFFSET, 16'h0080);
    // with eight taps every 3-bit index is legal: tap 0, corner 1 taken
    wr(SS_ADDR_SELECT, 16'h0081); rd(SS_ADDR_SELECT, 16'h0001);
    // same gain and offset on all four corners of tap 2 makes the blend exact
    q_g = 16'h0080 + ($random(seed) & 16'h00FF);
    q_o = $random(seed) & 16'h00FF;
    for (int c = 0; c < 4; c++) begin
      wr(SS_ADDR_SELECT, 16'h0020 | c[15:0]); wr(SS_ADDR_GAIN, q_g); wr(SS_ADDR_OFFSET, q_o);
    end
    // every enable combination, each with a back-to-back burst of pixels
    for (int m = 0; m < 4; m++) begin
      wr(SS_ADDR_CTRL, m[15:0]);
      rd(SS_ADDR_CTRL, m[15:0]);
      for (int i = 0; i < 16; i++) begin
        @(posedge mclk);
        src_send <= 1'b1; src_tap <= 3'h2;
        // first pixel of each burst at full scale, to reach the saturation path
        src_xf <= $random(seed); src_yf <= $random(seed);
        src_data <= (i == 0) ? 12'hFFF : 12'($random(seed));
        #1 pix_q.push_back(corr(src_data, m[0] ? q_g : 256, m[1] ? $signed(q_o[7:0]) : 0));
      end
      @(posedge mclk);
      src_send <= 1'b0;
      repeat (4) @(posedge mclk);
    end
    // store, refused write while busy, overwrite, recall restores
    wr(SS_ADDR_SELECT, 16'h0011); wr(SS_ADDR_GAIN, 16'h00C0);
    wr(SS_ADDR_CMD, 16'h0001); rd(SS_ADDR_STATUS, 16'h0001);
    wr(SS_ADDR_GAIN, 16'h0140);
    repeat (40) @(posedge mclk);
    rd(SS_ADDR_GAIN, 16'h00C0); wr(SS_ADDR_GAIN, 16'h0140); rd(SS_ADDR_GAIN, 16'h0140);
    wr(SS_ADDR_CMD, 16'h0002);
    repeat (40) @(posedge mclk);
    rd(SS_ADDR_GAIN, 16'h00C0); rd(SS_ADDR_STATUS, 16'h0002);
    repeat (4) @(posedge mclk);
    chk("queues_left", rd_q.size() + pix_q.size(), 16'h0000);
    tally_and_finish();
  end
endmodule
`default_nettype wire
